// [hw/cad_alu_datapath.sv]
// Purpose: 16-bit alu, multiplier, divider, shifter and core status
// Assumes: decoder presents one operation per cycle on ref_clk
// Notes:   results are registered; writeback belongs to the caller
// Behaviour
// RQ1: 16-bit unit for add, subtract, shifts and logic, two's complement.
// RQ2: byte or word operations; result routed to a working register or memory.
// RQ3: for subtraction carry and half carry hold the inverted borrow.
// RQ4: half carry is carry out of bit 3 (byte) or bit 7 (word).
// RQ5: negative flag copies the result sign.
// RQ6: overflow flag marks signed overflow of arithmetic.
// RQ7: zero flag changes only on operations that affect it.
// RQ8: carry flag is carry out of the result's top bit.
// RQ9: read-only repeat flag follows the repeat loop state.
// RQ10: three status priority bits plus control high bit form the priority level.
// RQ11: status priority bits ignore writes while nesting disable is set.
// RQ12: priority high bit is clear-only for software; disables user interrupts.
// RQ13: control bit 2 enables program space view in data space.
// RQ14: 17 by 17 multiplier, unsigned, signed and mixed.
// RQ15: word modes, 5-bit literal modes and byte by byte unsigned.
// RQ16: signed and unsigned 32 or 16 by 16 division.
// RQ17: quotient goes to working register 0, remainder to register 1.
// RQ18: any divisor register and any aligned register pair as dividend.
// RQ19: one step per divisor bit, same time for both dividend sizes.
// RQ20: divide finishes in 19 cycles and may pause at any cycle; the start cycle here ignores div_hold.
// RQ21: one-cycle arithmetic right or left shift by up to 15.
// RQ22: multi-bit shifts write back to a working register only.
// RQ23: arithmetic right, left and logical right shifts.
// RQ24: status and control registers readable and writable by instructions.
// RQ25: unimplemented bits read zero; implemented bits clear at reset.
// RQ26: flags keep their value over operations that do not affect them.
// RQ27: overflow is carry into sign xor carry out of sign.
`timescale 1ns/100ps
module cad_alu_datapath (
  input  logic                 ref_clk,
  input  logic                 reset,
  input  cad_pkg::cad_alu_req_t alu_in,
  input  cad_pkg::cad_div_req_t div_in,
  input  logic                 div_hold,
  input  cad_pkg::cad_reg_req_t reg_in,
  input  logic                 repeat_running,
  input  logic                 interrupt_nesting_disable,
  input  logic                 prio_load,
  input  logic [3:0]           prio_level,
  output cad_pkg::cad_alu_res_t alu_out,
  output cad_pkg::cad_div_res_t div_out,
  output logic                 div_busy,
  output logic [15:0]          reg_rdata,
  output logic                 reg_rvalid,
  output logic [15:0]          alu_flag_status,
  output logic [15:0]          cpu_core_control,
  output logic                 user_irq_disable
);
  import cad_pkg::*;

  // operand decode
  logic        byte_m;
  logic        is_sub;
  logic        use_c;
  logic        is_arith;
  logic        is_logic;
  logic        is_shift;
  logic        cin;
  logic [15:0] a;
  logic [15:0] b_eff;
  assign a        = alu_in.a;
  assign byte_m   = alu_in.byte_mode;
  assign is_sub   = alu_in.op inside {OP_SUB, OP_SUBB};
  assign use_c    = alu_in.op inside {OP_ADDC, OP_SUBB};
  assign is_arith = alu_in.op inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBB};
  assign is_logic = alu_in.op inside {OP_AND, OP_IOR, OP_XOR, OP_MOV};
  assign is_shift = alu_in.op inside {OP_ASR, OP_SL, OP_LSR};
  // subtract as a + ~b + 1, so carry is the inverted borrow
  assign b_eff    = is_sub ? ~alu_in.b : alu_in.b; // RQ3
  assign cin      = use_c ? alu_flag_status[ST_C] : is_sub;

  // adder with nibble and byte taps
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic [4:0]  sum_n;
  assign sum_w = {1'b0, a} + {1'b0, b_eff} + {16'h0000, cin}; // RQ1
  assign sum_b = {1'b0, a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
  assign sum_n = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};

  logic add_c;
  logic add_dc;
  logic add_ov;
  logic sgn_a;
  logic sgn_b;
  logic sgn_s;
  assign add_c  = byte_m ? sum_b[8] : sum_w[16]; // RQ8
  assign add_dc = byte_m ? sum_n[4] : sum_b[8]; // RQ4
  assign sgn_a  = byte_m ? a[7] : a[15];
  assign sgn_b  = byte_m ? b_eff[7] : b_eff[15];
  assign sgn_s  = byte_m ? sum_w[7] : sum_w[15];
  // carry into the sign bit is recovered from the sum bit
  assign add_ov = (sgn_s ^ sgn_a ^ sgn_b) ^ add_c; // RQ6 RQ27

  // barrel shifter, one cycle for any count
  logic [15:0] sh_src;
  logic [15:0] asr_r;
  logic [15:0] sl_r;
  logic [15:0] lsr_r;
  logic        sh_c;
  logic        sh_one;
  assign sh_src = !byte_m ? a :
                  (alu_in.op == OP_ASR) ? {{8{a[7]}}, a[7:0]} : {8'h00, a[7:0]};
  assign asr_r  = 16'($signed(sh_src) >>> alu_in.shamt); // RQ21 RQ23
  assign sl_r   = sh_src << alu_in.shamt; // RQ21 RQ23
  assign lsr_r  = sh_src >> alu_in.shamt; // RQ23
  assign sh_one = alu_in.shamt == 4'h1;
  assign sh_c   = (alu_in.op == OP_SL) ? sgn_a : a[0];

  // 17x17 signed core covers every sign mix
  logic        ma_s;
  logic        mb_s;
  logic [15:0] ma_src;
  logic [15:0] mb_src;
  logic [16:0] ma;
  logic [16:0] mb;
  logic [33:0] prod;
  assign ma_s   = alu_in.mul_mode inside {MUL_SS, MUL_SU, MUL_SLIT}; // RQ15
  assign mb_s   = alu_in.mul_mode inside {MUL_SS, MUL_US};
  assign ma_src = (alu_in.mul_mode == MUL_B8) ? {8'h00, a[7:0]} : a;
  assign mb_src = (alu_in.mul_mode inside {MUL_SLIT, MUL_ULIT}) ? {11'h000, alu_in.b[4:0]} :
                  (alu_in.mul_mode == MUL_B8) ? {8'h00, alu_in.b[7:0]} : alu_in.b;
  assign ma     = {ma_s & ma_src[15], ma_src};
  assign mb     = {mb_s & mb_src[15], mb_src};
  assign prod   = 34'($signed(ma) * $signed(mb)); // RQ14

  // result select
  logic [15:0] res_raw;
  logic [15:0] res;
  logic        res_z;
  logic        res_n;
  always_comb begin
    unique case (alu_in.op)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: res_raw = sum_w[15:0];
      OP_AND: res_raw = a & alu_in.b;
      OP_IOR: res_raw = a | alu_in.b;
      OP_XOR: res_raw = a ^ alu_in.b;
      OP_MOV: res_raw = a;
      OP_ASR: res_raw = asr_r;
      OP_SL:  res_raw = sl_r;
      OP_LSR: res_raw = lsr_r;
      OP_MUL: res_raw = prod[15:0];
      default: res_raw = 16'h0000;
    endcase
  end
  // byte results sit in the low lane; upper byte is driven as zero
  assign res   = (byte_m && alu_in.op != OP_MUL) ? {8'h00, res_raw[7:0]} : res_raw; // RQ2
  assign res_z = byte_m ? (res[7:0] == 8'h00) : (res == 16'h0000);
  assign res_n = byte_m ? res[7] : res[15];

  // which flags the operation touches
  logic upd_c;
  logic upd_arith;
  logic upd_nz;
  assign upd_c     = is_arith | (is_shift & sh_one);
  assign upd_arith = is_arith;
  assign upd_nz    = is_arith | is_logic | is_shift;

  cad_alu_res_t res_next;
  assign res_next = '{valid:     alu_in.valid,
                      data:      res,
                      data_hi:   (alu_in.op == OP_MUL) ? prod[31:16] : 16'h0000,
                      wide:      alu_in.op == OP_MUL,
                      byte_mode: byte_m,
                      dest_reg:  alu_in.dest_reg,
                      // multi-bit shifts cannot target memory
                      dest_mem:  alu_in.dest_mem & ~(is_shift & ~sh_one)}; // RQ22

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      alu_out <= '0;
    end else begin
      alu_out <= res_next; // RQ2
    end
  end

  // core registers
  logic        st_wr;
  logic        cc_wr;
  logic [15:0] st_next;
  logic [15:0] cc_next;
  assign st_wr = reg_in.wr && reg_in.sel == SEL_STATUS; // RQ24
  assign cc_wr = reg_in.wr && reg_in.sel == SEL_CONTROL; // RQ24

  always_comb begin
    st_next = alu_flag_status;
    if (st_wr && reg_in.be[0]) begin
      if (!interrupt_nesting_disable) begin
        st_next[ST_IPL_HI:ST_IPL_LO] = reg_in.wdata[ST_IPL_HI:ST_IPL_LO]; // RQ11
      end
      st_next[ST_N:ST_C] = reg_in.wdata[ST_N:ST_C];
    end
    if (st_wr && reg_in.be[1]) begin
      st_next[ST_DC] = reg_in.wdata[ST_DC];
    end
    // an alu result lands after the software write in the same cycle
    if (alu_in.valid && upd_c) begin
      st_next[ST_C] = is_shift ? sh_c : add_c; // RQ8 RQ3
    end
    if (alu_in.valid && upd_arith) begin
      st_next[ST_DC] = add_dc; // RQ4
      st_next[ST_OV] = add_ov; // RQ6
    end
    if (alu_in.valid && upd_nz) begin
      st_next[ST_N] = res_n; // RQ5
      // carry-chained ops may only clear zero, for multiword compares
      st_next[ST_Z] = use_c ? (alu_flag_status[ST_Z] & res_z) : res_z; // RQ7
    end
    if (prio_load) begin
      st_next[ST_IPL_HI:ST_IPL_LO] = prio_level[2:0]; // RQ10
    end
    st_next[ST_RA] = repeat_running; // RQ9
    st_next = st_next & ST_MASK; // RQ25
  end

  always_comb begin
    cc_next = cpu_core_control;
    if (cc_wr && reg_in.be[0]) begin
      cc_next[CC_PSV] = reg_in.wdata[CC_PSV]; // RQ13
      if (!reg_in.wdata[CC_CPU_PRIORITY_HIGH_BIT]) begin
        cc_next[CC_CPU_PRIORITY_HIGH_BIT] = 1'b0; // RQ12
      end
    end
    // hardware raise wins over a software clear
    if (prio_load) begin
      cc_next[CC_CPU_PRIORITY_HIGH_BIT] = prio_level[3]; // RQ10
    end
    cc_next = cc_next & CC_MASK; // RQ25
  end

  logic irq_off_next;
  assign irq_off_next = cc_next[CC_CPU_PRIORITY_HIGH_BIT] || st_next[ST_IPL_HI:ST_IPL_LO] == IPL_TOP; // RQ10 RQ12

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      alu_flag_status  <= ST_RESET; // RQ25
      cpu_core_control <= CC_RESET; // RQ25
      user_irq_disable <= 1'b0;
    end else begin
      alu_flag_status  <= st_next; // RQ26
      cpu_core_control <= cc_next;
      user_irq_disable <= irq_off_next;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= (reg_in.sel == SEL_CONTROL) ? cpu_core_control : alu_flag_status; // RQ24
      reg_rvalid <= reg_in.rd;
    end
  end

  // divider: setup, 16 steps, fixup
  typedef enum logic [1:0] {DV_IDLE, DV_SETUP, DV_ITER, DV_FIX} cad_dv_state_t;
  cad_dv_state_t dv_state_reg;
  cad_dv_state_t dv_state_next;
  logic [15:0]   dv_rem_reg;
  logic [15:0]   dv_quo_reg;
  logic [15:0]   dv_dvs_reg;
  logic [3:0]    dv_cnt_reg;
  logic          dv_sgn_reg;
  logic          dv_nq_reg;
  logic          dv_nr_reg;

  logic        dv_go;
  logic [31:0] dv_dend;
  logic [31:0] dv_abs;
  logic [17:0] dv_diff;
  logic        dv_fit;
  assign dv_go   = div_in.start && dv_state_reg == DV_IDLE;
  // short dividends are extended so both sizes run the same steps
  assign dv_dend = div_in.long_div ? div_in.dividend :
                   {{16{div_in.signed_div & div_in.dividend[15]}}, div_in.dividend[15:0]}; // RQ16 RQ18
  assign dv_abs  = (dv_sgn_reg && dv_rem_reg[15]) ? 32'(-{dv_rem_reg, dv_quo_reg}) :
                   {dv_rem_reg, dv_quo_reg};
  // quotient must fit 16 bits; larger quotients are not detected
  assign dv_diff = {1'b0, dv_rem_reg, dv_quo_reg[15]} - {2'b00, dv_dvs_reg};
  assign dv_fit  = !dv_diff[17];

  always_comb begin
    dv_state_next = dv_state_reg;
    unique case (dv_state_reg)
      DV_IDLE:  if (dv_go) dv_state_next = DV_SETUP;
      DV_SETUP: if (!div_hold) dv_state_next = DV_ITER; // RQ20
      DV_ITER:  if (!div_hold && dv_cnt_reg == DIV_LAST) dv_state_next = DV_FIX; // RQ19
      DV_FIX:   if (!div_hold) dv_state_next = DV_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dv_state_reg <= DV_IDLE;
      div_busy     <= 1'b0;
    end else begin
      dv_state_reg <= dv_state_next;
      div_busy     <= dv_state_next != DV_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dv_rem_reg <= 16'h0000;
      dv_quo_reg <= 16'h0000;
      dv_dvs_reg <= 16'h0000;
      dv_cnt_reg <= 4'h0;
      dv_sgn_reg <= 1'b0;
      dv_nq_reg  <= 1'b0;
      dv_nr_reg  <= 1'b0;
    end else if (dv_go) begin
      {dv_rem_reg, dv_quo_reg} <= dv_dend; // RQ18
      dv_dvs_reg <= div_in.divisor;
      dv_sgn_reg <= div_in.signed_div;
      dv_cnt_reg <= 4'h0;
    end else if (!div_hold && dv_state_reg == DV_SETUP) begin
      // work on magnitudes, signs restored at fixup
      {dv_rem_reg, dv_quo_reg} <= dv_abs;
      dv_dvs_reg <= (dv_sgn_reg && dv_dvs_reg[15]) ? 16'(-dv_dvs_reg) : dv_dvs_reg;
      dv_nq_reg  <= dv_sgn_reg & (dv_rem_reg[15] ^ dv_dvs_reg[15]);
      dv_nr_reg  <= dv_sgn_reg & dv_rem_reg[15];
    end else if (!div_hold && dv_state_reg == DV_ITER) begin
      dv_rem_reg <= dv_fit ? dv_diff[15:0] : {dv_rem_reg[14:0], dv_quo_reg[15]}; // RQ19
      dv_quo_reg <= {dv_quo_reg[14:0], dv_fit};
      dv_cnt_reg <= dv_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_out <= '0;
    end else if (!div_hold && dv_state_reg == DV_FIX) begin
      div_out.done             <= 1'b1;
      div_out.working_reg_zero <= dv_nq_reg ? 16'(-dv_quo_reg) : dv_quo_reg; // RQ17
      div_out.working_reg_one  <= dv_nr_reg ? 16'(-dv_rem_reg) : dv_rem_reg; // RQ17
    end else begin
      div_out.done <= 1'b0;
    end
  end

  // checking helpers
  logic [4:0]  chk_age;
  logic [31:0] chk_dend;
  logic [15:0] chk_dvs;
  logic        chk_sgn;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      chk_age  <= 5'h00;
      chk_dend <= 32'h0000_0000;
      chk_dvs  <= 16'h0000;
      chk_sgn  <= 1'b0;
    end else if (dv_go) begin
      chk_age  <= 5'h00;
      chk_dend <= dv_dend;
      chk_dvs  <= div_in.divisor;
      chk_sgn  <= div_in.signed_div;
    end else if (dv_state_reg != DV_IDLE && !div_hold) begin
      chk_age  <= chk_age + 5'h01;
    end
  end

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence dv_start_s;
    div_in.start && dv_state_reg == DV_IDLE;
  endsequence
  sequence dv_enter_s;
    div_busy && dv_state_reg == DV_SETUP;
  endsequence

  div_latency_a: assert property (div_out.done |-> chk_age == 5'(DIV_CYCLES - 1)) // RQ20
    else $error("divide did not take 19 cycles");
  div_enter_a: assert property (dv_start_s |=> dv_enter_s) // RQ20
    else $error("divide did not start");
  div_result_a: assert property (div_out.done && !chk_sgn && chk_dvs != 16'h0000 &&
                                 chk_dend[31:16] < chk_dvs |->
                                 {16'h0000, div_out.working_reg_zero} * {16'h0000, chk_dvs}
                                 + {16'h0000, div_out.working_reg_one} == chk_dend) // RQ17
    else $error("unsigned quotient and remainder wrong");
  sub_carry_a: assert property (alu_in.valid && alu_in.op == OP_SUB && !byte_m |=>
                                alu_flag_status[ST_C] == ($past(a) >= $past(alu_in.b))) // RQ3
    else $error("subtract carry is not inverted borrow");
  add_ovf_a: assert property (alu_in.valid && alu_in.op == OP_ADD && !byte_m |=>
                              alu_flag_status[ST_OV] == ($past(a[15]) == $past(alu_in.b[15]) &&
                              alu_out.data[15] != $past(a[15]))) // RQ6
    else $error("overflow flag wrong after add");
  zero_flag_a: assert property (alu_in.valid && is_logic && !byte_m |=>
                                alu_flag_status[ST_Z] == (alu_out.data == 16'h0000) &&
                                alu_flag_status[ST_N] == alu_out.data[15]) // RQ5
    else $error("zero or negative flag wrong");
  flag_hold_a: assert property (alu_in.valid && alu_in.op == OP_MUL && !reg_in.wr |=>
                                $stable(alu_flag_status[ST_N:ST_C])) // RQ26
    else $error("multiply changed a flag");
  mul_uu_a: assert property (alu_in.valid && alu_in.op == OP_MUL && alu_in.mul_mode == MUL_UU |=>
                             {alu_out.data_hi, alu_out.data} == $past(a) * $past(alu_in.b)) // RQ14
    else $error("unsigned product wrong");
  shift_left_a: assert property (alu_in.valid && alu_in.op == OP_SL && !byte_m |=>
                                 alu_out.data == 16'($past(a) << $past(alu_in.shamt))) // RQ21
    else $error("left shift result wrong");
  ipl_lock_a: assert property (interrupt_nesting_disable && st_wr && !prio_load |=>
                               $stable(alu_flag_status[ST_IPL_HI:ST_IPL_LO])) // RQ11
    else $error("locked priority bits changed");
  cpu_priority_high_bit_clear_a: assert property (cc_wr && !prio_load && !cpu_core_control[CC_CPU_PRIORITY_HIGH_BIT] |=>
                                 !cpu_core_control[CC_CPU_PRIORITY_HIGH_BIT]) // RQ12
    else $error("software set the priority high bit");
  irq_off_a: assert property (##1 user_irq_disable == (cpu_core_control[CC_CPU_PRIORITY_HIGH_BIT] ||
                              alu_flag_status[ST_IPL_HI:ST_IPL_LO] == IPL_TOP)) // RQ10
    else $error("user interrupt disable wrong");
  unimpl_zero_a: assert property (reg_rvalid |-> reg_rdata[15:9] == 7'h00) // RQ25
    else $error("unimplemented bits read non-zero");

endmodule : cad_alu_datapath

// [hw/cad_pkg.sv]
// Purpose: shared types and constants of the cpu alu datapath
// Assumes: 16-bit data path, one clock
// Notes:   register selectors stand in for the data-space addresses
package cad_pkg;

  // alu_flag_status field positions
  localparam int ST_C      = 0;
  localparam int ST_Z      = 1;
  localparam int ST_OV     = 2;
  localparam int ST_N      = 3;
  localparam int ST_RA     = 4;
  localparam int ST_IPL_LO = 5;
  localparam int ST_IPL_HI = 7;
  localparam int ST_DC     = 8;
  // cpu_core_control field positions
  localparam int CC_PSV    = 2;
  localparam int CC_CPU_PRIORITY_HIGH_BIT   = 3;

  localparam logic [15:0] ST_RESET   = 16'h0000;
  localparam logic [15:0] CC_RESET   = 16'h0000;
  localparam logic [15:0] ST_MASK    = 16'h01FF;
  localparam logic [15:0] CC_MASK    = 16'h000C;
  localparam logic [2:0]  IPL_TOP    = 3'h7;

  // register selectors on the core register port
  localparam logic SEL_STATUS  = 1'h0;
  localparam logic SEL_CONTROL = 1'h1;

  // divider timing: one step per divisor bit, 19 cycles in all
  localparam int DIV_STEPS  = 16;
  localparam int DIV_CYCLES = 19;
  localparam logic [3:0] DIV_LAST = 4'(DIV_STEPS - 1);

  typedef enum logic [3:0] {
    OP_ADD, OP_ADDC, OP_SUB, OP_SUBB, OP_AND, OP_IOR, OP_XOR,
    OP_MOV, OP_ASR, OP_SL, OP_LSR, OP_MUL
  } cad_op_t;

  typedef enum logic [2:0] {
    MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_B8
  } cad_mul_t;

  typedef struct packed {
    logic        valid;
    cad_op_t     op;
    logic        byte_mode;
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0]  shamt;
    cad_mul_t    mul_mode;
    logic [3:0]  dest_reg;
    logic        dest_mem;
  } cad_alu_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic [15:0] data_hi;
    logic        wide;
    logic        byte_mode;
    logic [3:0]  dest_reg;
    logic        dest_mem;
  } cad_alu_res_t;

  typedef struct packed {
    logic        start;
    logic        signed_div;
    logic        long_div;
    logic [31:0] dividend;
    logic [15:0] divisor;
  } cad_div_req_t;

  typedef struct packed {
    logic        done;
    logic [15:0] working_reg_zero;
    logic [15:0] working_reg_one;
  } cad_div_res_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        sel;
    logic [1:0]  be;
    logic [15:0] wdata;
  } cad_reg_req_t;

endpackage : cad_pkg

// [verif/cad_alu_datapath_bench.sv]
// Purpose: self-checking bench of the alu datapath
// Assumes: one request per task, inputs changed at the rising edge
// Notes:   divider hold is checked only inside the step phase
`timescale 1ns/100ps
module cad_alu_datapath_bench;
  import cad_pkg::*;
  logic         ref_clk = 1'b0;
  logic         reset = 1'b1;
  cad_alu_req_t alu_in = '0;
  cad_div_req_t div_in = '0;
  cad_reg_req_t reg_in = '0;
  logic         div_hold = 1'b0, rep_run = 1'b0, nest_dis = 1'b0, prio_load = 1'b0;
  logic [3:0]   prio_level = 4'h0, rsel = 4'h0;
  cad_alu_res_t alu_out;
  cad_div_res_t div_out;
  logic         div_busy, reg_rvalid, irq_dis;
  logic [15:0]  reg_rdata, status, control, rdata;
  int           error_cnt = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  cad_alu_datapath DUT (.ref_clk(ref_clk), .reset(reset), .alu_in(alu_in), .div_in(div_in),
    .div_hold(div_hold), .reg_in(reg_in), .repeat_running(rep_run), .interrupt_nesting_disable(nest_dis),
    .prio_load(prio_load), .prio_level(prio_level), .alu_out(alu_out), .div_out(div_out),
    .div_busy(div_busy), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .alu_flag_status(status),
    .cpu_core_control(control), .user_irq_disable(irq_dis));
  cad_decoder_model far_side (.ref_clk(ref_clk), .reset(reset), .alu_out(alu_out), .div_out(div_out),
    .rsel(rsel), .rdata(rdata));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic alu(cad_op_t op, logic bm, logic [15:0] a, b, logic [3:0] sh, cad_mul_t mm, logic mem);
    @(posedge ref_clk);
    alu_in <= '{1'b1, op, bm, a, b, sh, mm, 4'h2, mem};
    @(posedge ref_clk);
    alu_in.valid <= 1'b0;
    #1;
  endtask : alu
  task automatic reg_wr(logic sel, logic [1:0] be, logic [15:0] d);
    @(posedge ref_clk);
    reg_in <= '{1'b1, 1'b0, sel, be, d};
    @(posedge ref_clk);
    reg_in.wr <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic t_alu;
    cad_mul_t    mm [7] = '{MUL_SS, MUL_UU, MUL_SU, MUL_US, MUL_SLIT, MUL_ULIT, MUL_B8};
    logic [31:0] pe [7] = '{32'h1, 32'hFFFE0001, 32'hFFFF0001, 32'hFFFF0001, 32'hFFFFFFE1, 32'h1EFFE1, 32'hFE01};
    chk("reset status", 32'(status), 32'h0);
    chk("reset control", 32'(control), 32'h0);
    alu(OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 4'h0, MUL_SS, 1'b0);
    chk("add", 32'(alu_out.data), 32'h8000);
    chk("add flags", 32'(status), 32'h010C);
    alu(OP_SUB, 1'b0, 16'h0010, 16'h0010, 4'h0, MUL_SS, 1'b0);
    chk("sub flags", 32'(status), 32'h0103);
    alu(OP_SUB, 1'b1, 16'h0000, 16'h0001, 4'h0, MUL_SS, 1'b1);
    chk("byte sub", {alu_out.dest_mem, status[14:0], alu_out.data}, 32'h800800FF);
    alu(OP_ADD, 1'b1, 16'h007F, 16'h0001, 4'h0, MUL_SS, 1'b0);
    chk("byte add", {status, alu_out.data}, 32'h010C0080);
    for (int i = 0; i < 7; i++) begin
      alu(OP_MUL, 1'b0, 16'hFFFF, 16'hFFFF, 4'h0, mm[i], 1'b0);
      chk("product", {alu_out.data_hi, alu_out.data}, pe[i]);
    end
    chk("mul tags", {alu_out.valid, alu_out.wide, alu_out.dest_reg}, 32'h32);
    chk("flags kept", 32'(status), 32'h010C);
    alu(OP_XOR, 1'b0, 16'h5555, 16'h5555, 4'h0, MUL_SS, 1'b0);
    chk("xor zero", 32'(status[1]), 32'h1);
    $display("alu test done");
  endtask : t_alu
  task automatic t_shift;
    alu(OP_SL, 1'b0, 16'h0001, 16'h0000, 4'hF, MUL_SS, 1'b1);
    chk("sl 15", {alu_out.dest_mem, alu_out.data}, 32'h8000);
    alu(OP_ASR, 1'b0, 16'h8000, 16'h0000, 4'hF, MUL_SS, 1'b0);
    chk("asr 15", 32'(alu_out.data), 32'hFFFF);
    alu(OP_LSR, 1'b0, 16'h8000, 16'h0000, 4'hF, MUL_SS, 1'b0);
    chk("lsr 15", 32'(alu_out.data), 32'h0001);
    alu(OP_SL, 1'b0, 16'h8001, 16'h0000, 4'h1, MUL_SS, 1'b0);
    chk("sl 1", {status[0], alu_out.data}, 32'h10002);
    @(posedge ref_clk);
    #1;
    rsel = 4'h2;
    #1;
    chk("writeback", 32'(rdata), 32'h0002);
    $display("shift test done");
  endtask : t_shift
  task automatic div_run(logic sg, logic lg, logic [31:0] dd, logic [15:0] dv, int hold, logic [31:0] qr);
    int n;
    @(posedge ref_clk);
    div_in <= '{1'b1, sg, lg, dd, dv};
    @(posedge ref_clk);
    div_in.start <= 1'b0;
    #1;
    n = 1;
    chk("div busy", 32'(div_busy), 32'h1);
    while (div_out.done !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      div_hold <= (n > 4 && n <= 4 + hold);
      n++;
      #1;
    end
    chk("div cycles", n, 19 + hold);
    chk("div end", {div_busy, div_out.done}, 32'h1);
    @(posedge ref_clk);
    #1;
    rsel = 4'h1;
    #1;
    chk("quot rem", {far_side.wreg[0], rdata}, qr);
  endtask : div_run
  task automatic t_div;
    div_run(1'b0, 1'b1, 32'h00010005, 16'h0002, 0, 32'h80020001);
    div_run(1'b1, 1'b0, 32'h0000FFF9, 16'h0002, 2, 32'hFFFDFFFF);
    div_run(1'b1, 1'b1, 32'hFFFFFFF9, 16'h0002, 0, 32'hFFFDFFFF);
    div_run(1'b0, 1'b0, 32'h00000064, 16'h0007, 3, 32'h000E0002);
    $display("divide test done");
  endtask : t_div
  task automatic t_regs;
    reg_wr(SEL_CONTROL, 2'h3, 16'hFFFF);
    chk("control", 32'(control), 32'h0004);
    nest_dis <= 1'b1;
    rep_run <= 1'b1;
    reg_wr(SEL_STATUS, 2'h3, 16'hFFFF);
    chk("locked status", 32'(status), 32'h011F);
    nest_dis <= 1'b0;
    reg_wr(SEL_STATUS, 2'h1, 16'h00E0);
    @(posedge ref_clk);
    #1;
    chk("prio 7", {irq_dis, status}, 32'h101F0);
    @(posedge ref_clk);
    reg_in <= '{1'b0, 1'b1, SEL_STATUS, 2'h3, 16'h0000};
    prio_load <= 1'b1;
    prio_level <= 4'h8;
    @(posedge ref_clk);
    reg_in.rd <= 1'b0;
    prio_load <= 1'b0;
    #1;
    chk("read", {reg_rvalid, reg_rdata}, 32'h101F0);
    reg_wr(SEL_CONTROL, 2'h1, 16'h0008);
    chk("high prio", {irq_dis, status[7:5], control}, 32'h80008);
    rep_run <= 1'b0;
    reg_wr(SEL_CONTROL, 2'h1, 16'h0000);
    @(posedge ref_clk);
    #1;
    chk("prio cleared", {irq_dis, status[4], control}, 32'h0);
    $display("register test done");
  endtask : t_regs
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    t_alu;
    t_shift;
    t_div;
    t_regs;
    report_and_stop;
  end
  // whole run is under two hundred cycles; cut a hang at 2000
  initial begin
    #50000;
    error_cnt++;
    report_and_stop;
  end
endmodule : cad_alu_datapath_bench

// [verif/cad_decoder_model.sv]
// Purpose: working register file behind the datapath
// Assumes: results land one edge after the datapath shows them
// Notes:   memory destinations are dropped, only registers are kept
`timescale 1ns/100ps
module cad_decoder_model (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire cad_pkg::cad_alu_res_t alu_out,
  input  wire cad_pkg::cad_div_res_t div_out,
  input  wire logic [3:0]            rsel,
  output logic [15:0]                rdata
);
  import cad_pkg::*;
  logic [15:0] wreg [16];
  assign rdata = wreg[rsel];
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        wreg[i] <= 16'h0000;
      end
    end else if (div_out.done) begin
      wreg[0] <= div_out.working_reg_zero;
      wreg[1] <= div_out.working_reg_one;
    end else if (alu_out.valid && !alu_out.dest_mem) begin
      wreg[alu_out.dest_reg] <= alu_out.data;
    end
  end
endmodule : cad_decoder_model
